// ### core/fspc_defines.vh
/*
 * Constants of the flash self-program control block: register offsets,
 * field positions, reset values and the instruction window lengths.
 * Assumes inclusion by bare name from the core/ design files.
 */
`ifndef FSPC_DEFINES_VH
`define FSPC_DEFINES_VH

// apb byte offsets, one aligned word each
`define FSPC_OFS_CTRL 8'h00
`define FSPC_OFS_IRQ_STAT 8'h04
`define FSPC_OFS_IRQ_MASK 8'h08
`define FSPC_OFS_LOCK 8'h0C
`define FSPC_OFS_FUSE 8'h10

// self_program_ctrl_status fields
`define FSPC_B_SPE 0
`define FSPC_B_ERASE 1
`define FSPC_B_WRITE 2
`define FSPC_B_LOCKSET 3
`define FSPC_B_RDEN 4
`define FSPC_B_UNUSED 5
`define FSPC_B_BUSY 6
`define FSPC_B_IRQEN 7
`define FSPC_CTRL_RESET 8'h00

// interrupt status / mask fields
`define FSPC_IRQ_N 3
`define FSPC_IB_READY 0
`define FSPC_IB_LOCK 1
`define FSPC_IB_TIMEOUT 2
`define FSPC_IRQ_RESET 3'h0

// lock bits value after reset
`define FSPC_LOCK_RESET 8'hFF

// instruction windows in clock cycles
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3

// application reset vector
`define FSPC_APP_VECTOR 16'h0000

`endif

// ### core/fspc_window_timer.v
/*
 * Window timer: opens for COUNT cycles after start, closes early on stop,
 * and gives a one-cycle expire pulse when it runs out unused.
 * Assumes start and stop are synchronous single-cycle strobes.
 */
`default_nettype none

module fspc_window_timer #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] COUNT = 3'h4
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire start_i,
    input wire stop_i,
    output wire active_o,
    output reg expire_o
);

    reg [WIDTH-1:0] cnt_ff;

    assign active_o = (cnt_ff != {WIDTH{1'b0}});

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_ff <= {WIDTH{1'b0}};
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (start_i) begin
                cnt_ff <= COUNT;
            end else if (stop_i) begin
                cnt_ff <= {WIDTH{1'b0}};
            end else if (active_o) begin
                cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
                if (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    expire_o <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### core/fspc_irq_bank.v
/*
 * Sticky interrupt status with write-one-to-clear and a mask register.
 * A set in the same cycle as a clear wins. Assumes one-cycle event pulses.
 */
`default_nettype none

module fspc_irq_bank #(
    parameter N = 3
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire [N-1:0] event_i,
    input wire [N-1:0] clear_i,
    input wire mask_we_i,
    input wire [N-1:0] mask_i,
    output reg [N-1:0] status_o,
    output reg [N-1:0] mask_o,
    output reg irq_o
);

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    status_o[i] <= 1'b0;
                end else if (event_i[i]) begin
                    status_o[i] <= 1'b1;
                end else if (clear_i[i]) begin
                    status_o[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            mask_o <= {N{1'b0}};
            irq_o <= 1'b0;
        end else begin
            if (mask_we_i) begin
                mask_o <= mask_i;
            end
            // one cycle behind status, keeps the output a plain flop
            irq_o <= |(status_o & mask_o);
        end
    end

endmodule

`default_nettype wire

// ### core/fspc_top.v
/*
 * Flash self-program control: control/status register, store and load
 * instruction windows, section busy tracking, lock bits, reset vector and
 * interrupts, reached over APB.
 * Assumes the core gives one-cycle instruction strobes and the flash
 * controller a one-cycle done pulse; all inputs are synchronous.
 */
// Summary of operation
// - reset vector zero unless boot fuse programmed
// - fuses are read only to software
// - ready irq while enabled and program idle
// - erase or write sets section busy
// - busy flag blocks section access
// - busy clears on read enable or load
// - self-program enable clears on completion
// - read-enable store in window reopens section
// - no reopen while operation in progress
// - read enable during loading discards buffer
// - lock-set store copies r0 into locks
// - lock-set clears on finish or timeout
// - load in window returns lock or fuse
// - bit five always reads zero
`default_nettype none
`include "fspc_defines.vh"

module fspc_top #(
    parameter [15:0] BOOT_VECTOR = 16'h0F00,
    parameter [7:0] LOCK_RESET = `FSPC_LOCK_RESET
) (
    input wire core_clk_i,
    input wire rst_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // processor core side
    input wire store_program_instr_i,
    input wire load_program_instr_i,
    input wire [7:0] r0_data_i,
    input wire z0_i,
    input wire global_irq_en_i,
    output reg [7:0] load_data_o,
    output reg load_valid_o,
    output reg ready_irq_o,
    // flash side
    input wire flash_done_i,
    input wire [7:0] fuse_bits_i,
    input wire boot_reset_fuse_i,
    output reg page_erase_o,
    output reg page_write_o,
    output reg page_load_o,
    output reg buffer_discard_o,
    output reg section_blocked_o,
    output reg [7:0] lock_bits_o,
    output reg [15:0] reset_vector_o,
    output reg irq_o
);

    function sel_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            sel_hit = (addr == ofs);
        end
    endfunction

    // control bits
    reg spe_ff;
    reg erase_ff;
    reg write_ff;
    reg lockset_ff;
    reg rden_ff;
    reg busy_ff;
    reg irqen_ff;
    reg op_busy_ff;
    reg buf_loaded_ff;
    reg nxt_spe;
    reg nxt_erase;
    reg nxt_write;
    reg nxt_lockset;
    reg nxt_rden;
    reg nxt_busy;
    reg nxt_op_busy;
    reg nxt_buf_loaded;

    wire [`FSPC_IRQ_N-1:0] irq_status;
    wire [`FSPC_IRQ_N-1:0] irq_mask;
    wire [7:0] ctrl_rd;

    // both windows are short, so one narrow counter width serves them
    localparam WIN_W = 3;

    // apb decode; a request completes in its first access cycle
    wire apb_access = psel_i & penable_i & pready_o;
    wire apb_wr = apb_access & pwrite_i;
    wire wr_ctrl = apb_wr & sel_hit(paddr_i, `FSPC_OFS_CTRL);
    wire wr_stat = apb_wr & sel_hit(paddr_i, `FSPC_OFS_IRQ_STAT);
    wire wr_mask = apb_wr & sel_hit(paddr_i, `FSPC_OFS_IRQ_MASK);
    wire addr_ok = sel_hit(paddr_i, `FSPC_OFS_CTRL) |
                   sel_hit(paddr_i, `FSPC_OFS_IRQ_STAT) |
                   sel_hit(paddr_i, `FSPC_OFS_IRQ_MASK) |
                   sel_hit(paddr_i, `FSPC_OFS_LOCK) |
                   sel_hit(paddr_i, `FSPC_OFS_FUSE);

    wire w_spe = pwdata_i[`FSPC_B_SPE];
    wire w_rden = pwdata_i[`FSPC_B_RDEN];
    wire w_lockset = pwdata_i[`FSPC_B_LOCKSET];
    wire w_erase = pwdata_i[`FSPC_B_ERASE];
    wire w_write = pwdata_i[`FSPC_B_WRITE];
    wire w_irqen = pwdata_i[`FSPC_B_IRQEN];

    // windows
    wire store_win_open;
    wire store_win_exp;
    wire load_win_open;
    // a store outside its window is ignored, exactly like a late one
    wire store_take = store_program_instr_i & store_win_open & spe_ff;
    // a lone lock-set bit without the enable opens nothing
    wire load_start = wr_ctrl & ~op_busy_ff & w_spe & w_lockset;
    wire store_start = wr_ctrl & ~op_busy_ff & w_spe;

    fspc_window_timer #(
        .WIDTH(WIN_W),
        .COUNT(`FSPC_STORE_WIN)
    ) u_store_win (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(store_start),
        .stop_i(store_take),
        .active_o(store_win_open),
        .expire_o(store_win_exp)
    );

    fspc_window_timer #(
        .WIDTH(WIN_W),
        .COUNT(`FSPC_LOAD_WIN)
    ) u_load_win (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(load_start),
        .stop_i(1'b0),
        .active_o(load_win_open),
        .expire_o()
    );

    // store instruction decode, one command at a time
    wire cmd_erase = store_take & erase_ff;
    wire cmd_write = store_take & write_ff & ~erase_ff;
    wire cmd_lock = store_take & lockset_ff & ~erase_ff & ~write_ff;
    wire cmd_rden = store_take & rden_ff & ~lockset_ff & ~erase_ff & ~write_ff;
    wire cmd_load = store_take & ~rden_ff & ~lockset_ff & ~erase_ff & ~write_ff;
    wire op_done = op_busy_ff & flash_done_i;
    // only words left by plain page loads can be thrown away
    wire rden_discard = wr_ctrl & w_rden & buf_loaded_ff & ~op_busy_ff;
    wire win_timeout = store_win_exp & spe_ff & ~op_busy_ff;

    always @* begin
        nxt_spe = spe_ff;
        nxt_erase = erase_ff;
        nxt_write = write_ff;
        nxt_lockset = lockset_ff;
        nxt_rden = rden_ff;
        nxt_busy = busy_ff;
        nxt_op_busy = op_busy_ff;
        nxt_buf_loaded = buf_loaded_ff;
        // while programming, the command bits are frozen
        if (wr_ctrl & ~op_busy_ff) begin
            nxt_spe = w_spe;
            nxt_erase = w_erase;
            nxt_write = w_write;
            nxt_lockset = w_lockset;
            nxt_rden = w_rden;
        end
        if (rden_discard) begin
            nxt_buf_loaded = 1'b0;
        end
        if (cmd_erase | cmd_write) begin
            nxt_busy = 1'b1;
            nxt_op_busy = 1'b1;
        end
        if (cmd_load) begin
            nxt_busy = 1'b0;
            nxt_buf_loaded = 1'b1;
            nxt_spe = 1'b0;
        end
        if (cmd_rden) begin
            nxt_busy = 1'b0;
            nxt_rden = 1'b0;
            nxt_spe = 1'b0;
        end
        if (cmd_lock) begin
            nxt_lockset = 1'b0;
            nxt_spe = 1'b0;
        end
        // a stale enable must not arm a store much later
        if (win_timeout) begin
            nxt_spe = 1'b0;
            nxt_erase = 1'b0;
            nxt_write = 1'b0;
            nxt_lockset = 1'b0;
            nxt_rden = 1'b0;
        end
        // completion is decoded last so it wins over anything in the same cycle
        if (op_done) begin
            nxt_op_busy = 1'b0;
            nxt_spe = 1'b0;
            nxt_erase = 1'b0;
            nxt_write = 1'b0;
            // a write empties the page buffer into flash
            nxt_buf_loaded = 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            spe_ff <= 1'b0;
            erase_ff <= 1'b0;
            write_ff <= 1'b0;
            lockset_ff <= 1'b0;
            rden_ff <= 1'b0;
            busy_ff <= 1'b0;
            irqen_ff <= 1'b0;
            op_busy_ff <= 1'b0;
            buf_loaded_ff <= 1'b0;
        end else begin
            spe_ff <= nxt_spe;
            erase_ff <= nxt_erase;
            write_ff <= nxt_write;
            lockset_ff <= nxt_lockset;
            rden_ff <= nxt_rden;
            busy_ff <= nxt_busy;
            op_busy_ff <= nxt_op_busy;
            buf_loaded_ff <= nxt_buf_loaded;
            if (wr_ctrl) begin
                irqen_ff <= w_irqen;
            end
        end
    end

    assign ctrl_rd = {irqen_ff, busy_ff, 1'b0, rden_ff,
                      lockset_ff, write_ff, erase_ff, spe_ff};

    // flash strobes, lock bits, ready request and blocking
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            page_erase_o <= 1'b0;
            page_write_o <= 1'b0;
            page_load_o <= 1'b0;
            buffer_discard_o <= 1'b0;
            section_blocked_o <= 1'b0;
            lock_bits_o <= LOCK_RESET;
            ready_irq_o <= 1'b0;
        end else begin
            page_erase_o <= cmd_erase;
            page_write_o <= cmd_write;
            page_load_o <= cmd_load;
            buffer_discard_o <= rden_discard;
            // next value, so the pin never lags the busy bit by a cycle
            section_blocked_o <= nxt_busy;
            // only register zero matters; pointer and other data are ignored
            if (cmd_lock) begin
                lock_bits_o <= r0_data_i;
            end
            // a level, not a pulse: the core keeps taking it while idle
            ready_irq_o <= irqen_ff & global_irq_en_i & ~spe_ff;
        end
    end

    // lock or fuse readback inside the load window
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            load_data_o <= 8'h00;
            load_valid_o <= 1'b0;
        end else begin
            load_valid_o <= 1'b0;
            // the store window keeps running; its timeout tidies up afterwards
            if (load_program_instr_i & load_win_open & lockset_ff & spe_ff) begin
                load_data_o <= z0_i ? fuse_bits_i : lock_bits_o;
                load_valid_o <= 1'b1;
            end
        end
    end

    // vector follows the fuse; nothing here can write a fuse
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            // taken only in reset, so a later fuse change has no effect
            reset_vector_o <= boot_reset_fuse_i ? `FSPC_APP_VECTOR : BOOT_VECTOR;
        end
    end

    // events: program finished, lock update done, window ran out
    wire [`FSPC_IRQ_N-1:0] irq_events;
    assign irq_events[`FSPC_IB_READY] = spe_ff & ~nxt_spe;
    assign irq_events[`FSPC_IB_LOCK] = cmd_lock;
    assign irq_events[`FSPC_IB_TIMEOUT] = win_timeout;

    fspc_irq_bank #(
        .N(`FSPC_IRQ_N)
    ) u_irq (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .event_i(irq_events),
        .clear_i(pwdata_i[`FSPC_IRQ_N-1:0] & {`FSPC_IRQ_N{wr_stat}}),
        .mask_we_i(wr_mask),
        .mask_i(pwdata_i[`FSPC_IRQ_N-1:0]),
        .status_o(irq_status),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    // apb slave, zero wait states; fuse word is read only
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= psel_i & ~penable_i;
            // unmapped words still complete at once, with an error
            pslverr_o <= psel_i & ~penable_i & ~addr_ok;
            prdata_o <= 32'h00000000;
            if (psel_i & ~penable_i & ~pwrite_i) begin
                case (paddr_i)
                    `FSPC_OFS_CTRL: prdata_o <= {24'h000000, ctrl_rd};
                    `FSPC_OFS_IRQ_STAT: prdata_o <= {29'h00000000, irq_status};
                    `FSPC_OFS_IRQ_MASK: prdata_o <= {29'h00000000, irq_mask};
                    `FSPC_OFS_LOCK: prdata_o <= {24'h000000, lock_bits_o};
                    `FSPC_OFS_FUSE: prdata_o <= {23'h000000, boot_reset_fuse_i,
                                                 fuse_bits_i};
                    default: prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ### verif/fspc_chk.sv
/*
 * Assertion checker for the ports of fspc_top.
 * Assumes it is bound into fspc_top, with one clock and a synchronous high reset.
 */
`default_nettype none
module fspc_chk #(
    parameter logic [15:0] BOOT_VECTOR = 16'h0F00
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic store_program_instr_i,
    input wire logic load_program_instr_i,
    input wire logic z0_i,
    input wire logic global_irq_en_i,
    input wire logic [7:0] fuse_bits_i,
    input wire logic boot_reset_fuse_i,
    input wire logic [7:0] load_data_o,
    input wire logic load_valid_o,
    input wire logic ready_irq_o,
    input wire logic page_erase_o,
    input wire logic page_write_o,
    input wire logic page_load_o,
    input wire logic section_blocked_o,
    input wire logic [7:0] lock_bits_o,
    input wire logic [15:0] reset_vector_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_cmd;
        page_erase_o || page_write_o || page_load_o;
    endsequence
    vec_sel_a: assert property ($fell(rst_i) |-> reset_vector_o ==
        ($past(boot_reset_fuse_i) ? 16'h0000 : BOOT_VECTOR)) else $error("bad reset vector");
    busy_set_a: assert property ((page_erase_o || page_write_o) |-> section_blocked_o)
        else $error("section not blocked");
    cmd_cause_a: assert property (s_cmd |-> $past(store_program_instr_i))
        else $error("command without store");
    load_free_a: assert property (page_load_o |-> !section_blocked_o)
        else $error("busy kept on page load");
    ready_gie_a: assert property (ready_irq_o |-> $past(global_irq_en_i))
        else $error("ready irq without global enable");
    load_src_a: assert property (load_valid_o |-> $past(load_program_instr_i) &&
        load_data_o == ($past(z0_i) ? $past(fuse_bits_i) : $past(lock_bits_o)))
        else $error("bad load data");
    lock_hold_a: assert property (!$past(store_program_instr_i) |-> $stable(lock_bits_o))
        else $error("lock bits changed without store");
    apb_wait_a: assert property (s_setup |=> pready_o) else $error("no ready");
    apb_one_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
    err_rdy_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
endmodule
`default_nettype wire

// ### verif/fspc_core_model.sv
/*
 * Model of the processor core and flash array beside fspc_top.
 * Assumes its tasks are called right after a rising clock edge.
 */
`default_nettype none
module fspc_core_model (
    input wire logic core_clk_i,
    output logic store_o,
    output logic load_o,
    output logic [7:0] r0_o,
    output logic z0_o,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {store_o, load_o, r0_o, z0_o, done_o} = 12'h000;
    end
    // issued in the first cycle of the window, so it is always in time
    task automatic store(input logic [7:0] r0);
        store_o <= 1'b1;
        r0_o <= r0;
        @(posedge core_clk_i);
        store_o <= 1'b0;
        // register no longer qualified: show the inverse, not a held value
        r0_o <= ~r0;
    endtask
    task automatic load(input logic z0);
        load_o <= 1'b1;
        z0_o <= z0;
        @(posedge core_clk_i);
        load_o <= 1'b0;
        z0_o <= ~z0;
    endtask
    task automatic finish_op();
        done_o <= 1'b1;
        @(posedge core_clk_i);
        done_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/*
 * Self-checking bench for fspc_top: apb tasks, core model, checker bind.
 * Assumes the core/ design files, the checker and the core model are compiled first.
 */
`default_nettype none
`include "fspc_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, gie = 1'b0, bfuse = 1'b1, seen_disc = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [1:0] seen_ew = 2'h0;
    logic [31:0] pwdata = 32'h0, rd;
    logic err;
    int n_fail = 0, n_checks = 0, cyc = 0;
    wire logic [31:0] prdata;
    wire logic [15:0] vec;
    wire logic [7:0] load_data, lock, r0;
    wire logic pready, pslverr, load_valid, ready_irq, erase, write, pload, disc, blocked, irq;
    wire logic store, load, z0, done;
    fspc_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .store_program_instr_i(store),
        .load_program_instr_i(load), .r0_data_i(r0), .z0_i(z0), .global_irq_en_i(gie),
        .load_data_o(load_data), .load_valid_o(load_valid), .ready_irq_o(ready_irq),
        .flash_done_i(done), .fuse_bits_i(8'h5A), .boot_reset_fuse_i(bfuse),
        .page_erase_o(erase), .page_write_o(write), .page_load_o(pload),
        .buffer_discard_o(disc), .section_blocked_o(blocked), .lock_bits_o(lock),
        .reset_vector_o(vec), .irq_o(irq));
    fspc_core_model u_core (.core_clk_i(core_clk_i), .store_o(store), .load_o(load),
        .r0_o(r0), .z0_o(z0), .done_o(done));
    always #5 core_clk_i = ~core_clk_i;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (disc === 1'b1) seen_disc <= 1'b1;
        if (erase === 1'b1) seen_ew[0] <= 1'b1;
        if (write === 1'b1) seen_ew[1] <= 1'b1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // an idle edge first, so back-to-back calls never drive psel twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        pen <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        chk(vec, 16'h0000);
        rdchk(`FSPC_OFS_CTRL, 32'h0);
        rdchk(`FSPC_OFS_LOCK, 32'hFF);
        apb(1'b1, `FSPC_OFS_FUSE, 32'h0);
        rdchk(`FSPC_OFS_FUSE, 32'h15A);
        apb(1'b1, `FSPC_OFS_CTRL, 32'hA0);
        rdchk(`FSPC_OFS_CTRL, 32'h80);
        apb(1'b0, 8'h14, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test regs done");
        apb(1'b1, `FSPC_OFS_IRQ_MASK, 32'h6);
        gie <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `FSPC_OFS_CTRL, i ? 32'h85 : 32'h83);
            u_core.store(8'h00);
            rdchk(`FSPC_OFS_CTRL, i ? 32'hC5 : 32'hC3);
            chk({blocked, ready_irq}, 2'b10);
            apb(1'b1, `FSPC_OFS_CTRL, 32'h91);
            rdchk(`FSPC_OFS_CTRL, i ? 32'hC5 : 32'hC3);
            u_core.finish_op();
            rdchk(`FSPC_OFS_CTRL, 32'hC0);
            chk(ready_irq, 1'b1);
            if (i == 0) begin
                rdchk(`FSPC_OFS_IRQ_STAT, 32'h1);
                chk(irq, 1'b0);
                apb(1'b1, `FSPC_OFS_IRQ_MASK, 32'h7);
                rdchk(`FSPC_OFS_IRQ_MASK, 32'h7);
                chk(irq, 1'b1);
                apb(1'b1, `FSPC_OFS_IRQ_STAT, 32'h1);
                rdchk(`FSPC_OFS_IRQ_STAT, 32'h0);
                chk(irq, 1'b0);
            end
            apb(1'b1, `FSPC_OFS_CTRL, i ? 32'h81 : 32'h91);
            u_core.store(8'h00);
            @(posedge core_clk_i);
            chk({blocked, pload}, {1'b0, i[0]});
        end
        apb(1'b1, `FSPC_OFS_CTRL, 32'h11);
        repeat (3) @(posedge core_clk_i);
        chk(seen_disc, 1'b1);
        chk(seen_ew, 2'h3);
        $display("test program done");
        apb(1'b1, `FSPC_OFS_CTRL, 32'h09);
        u_core.store(8'hA5);
        rdchk(`FSPC_OFS_CTRL, 32'h0);
        chk(lock, 8'hA5);
        for (int z = 0; z < 2; z++) begin
            repeat (4) @(posedge core_clk_i);
            apb(1'b1, `FSPC_OFS_CTRL, 32'h09);
            u_core.load(z[0]);
            @(posedge core_clk_i);
            chk({load_valid, load_data}, z ? 9'h15A : 9'h1A5);
        end
        repeat (4) @(posedge core_clk_i);
        apb(1'b1, `FSPC_OFS_IRQ_STAT, 32'h7);
        apb(1'b1, `FSPC_OFS_CTRL, 32'h09);
        repeat (6) @(posedge core_clk_i);
        rdchk(`FSPC_OFS_CTRL, 32'h0);
        apb(1'b0, `FSPC_OFS_IRQ_STAT, 32'h0);
        chk(rd & 32'h4, 32'h4);
        $display("test lock done");
        bfuse <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        chk({vec, lock}, 24'h0F00FF);
        $display("test reset done");
        finish_test();
    end
endmodule
bind fspc_top fspc_chk #(.BOOT_VECTOR(BOOT_VECTOR)) u_chk (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .store_program_instr_i(store_program_instr_i),
    .load_program_instr_i(load_program_instr_i), .z0_i(z0_i),
    .global_irq_en_i(global_irq_en_i), .fuse_bits_i(fuse_bits_i),
    .boot_reset_fuse_i(boot_reset_fuse_i), .load_data_o(load_data_o),
    .load_valid_o(load_valid_o), .ready_irq_o(ready_irq_o), .page_erase_o(page_erase_o),
    .page_write_o(page_write_o), .page_load_o(page_load_o),
    .section_blocked_o(section_blocked_o), .lock_bits_o(lock_bits_o),
    .reset_vector_o(reset_vector_o));
`default_nettype wire
